// ==== pkg/ddwb_pkg.sv ====
// Constants and types for the DDR3 write burst and precharge block.
// Assumes the pin bundle is sampled by the mclk domain only.
package ddwb_pkg;
	// Positions inside the sampled pin bundle
	localparam int PIN_DM = 0;
	localparam int PIN_DQ_LO = 1;
	localparam int PIN_DQ_HI = 8;
	localparam int PIN_DQS = 9;
	localparam int PIN_ADDR_LO = 10;
	localparam int PIN_ADDR_HI = 25;
	localparam int PIN_BA_LO = 26;
	localparam int PIN_BA_HI = 28;
	localparam int PIN_WE_N = 29;
	localparam int PIN_CAS_N = 30;
	localparam int PIN_RAS_N = 31;
	localparam int PIN_CS_N = 32;
	localparam int PIN_CK = 33;
	localparam int PIN_W = 34;
	// Address bits with special meaning
	localparam int ADDR_CHOP = 12;
	localparam int ADDR_ALLBANK = 10;
	localparam int COL_W = 10;
	localparam int DATA_W = 8;
	localparam int BANKS = 8;
	// Burst field of mode register 0
	localparam logic [1:0] BURST_FIXED8 = 2'h0;
	localparam logic [1:0] BURST_OTF = 2'h1;
	localparam logic [1:0] BURST_FIXED4 = 2'h2;
	// Beat counts and clock cycles spent per burst
	localparam logic [3:0] BEATS_FULL = 4'h8;
	localparam logic [3:0] BEATS_CHOP = 4'h4;
	localparam logic [5:0] CK_FULL = 6'h04;
	localparam logic [5:0] CK_CHOP = 6'h02;
	// Link clock cycles allowed past the last beat before giving up
	localparam logic [5:0] CK_SLACK = 6'h03;
	// Stored beat: bank, column, data
	localparam int BEAT_W = 3 + COL_W + DATA_W;
	typedef enum logic [0:0] {ST_IDLE, ST_BURST} ddwb_state_e;
endpackage : ddwb_pkg

// ==== rtl/ddwb_core.sv ====
// DDR3 write burst capture, write mask and precharge bank tracking.
// Assumes all pins, link clock included, arrive asynchronous to mclk.
`timescale 1ns/1ps
module ddwb_core
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ddrClk,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [2:0] bankAddr,
	input wire logic [15:0] addr,
	input wire logic dqs,
	input wire logic [7:0] dq,
	input wire logic dm,
	input wire logic [1:0] burstMode,
	input wire logic [3:0] addLat,
	input wire logic [3:0] casWriteLat,
	input wire logic storeReady,
	output logic storeValid,
	output logic [2:0] storeBank,
	output logic [9:0] storeCol,
	output logic [7:0] storeData,
	output logic [7:0] bankOpen,
	output logic burstBusy,
	output logic overrun,
	output logic burstAbort
);

	typedef struct packed {
		logic [ddwb_pkg::PIN_W-1:0] sync1;
		logic [ddwb_pkg::PIN_W-1:0] sync2;
		logic [ddwb_pkg::PIN_W-1:0] sync3;
		logic ckLvl;
		logic dqsLvl;
		ddwb_pkg::ddwb_state_e state;
		logic [5:0] ckCnt;
		logic [5:0] wlat;
		logic chop;
		logic [2:0] bank;
		logic [9:0] col;
		logic [3:0] beat;
		logic preSeen;
		logic [ddwb_pkg::BEAT_W-1:0] head;
		logic [ddwb_pkg::BEAT_W-1:0] tail;
		logic headVal;
		logic tailVal;
		logic [7:0] bankOpen;
		logic overrun;
		logic abort;
		logic busy;
	} ddwb_st_s;

	ddwb_st_s r_q;
	ddwb_st_s r_d;

	logic ckRise;
	logic dqsEdge;
	logic cmdValid;
	logic isWrite;
	logic isPrecharge;
	logic isActivate;
	logic [3:0] beatsNeed;
	logic [5:0] ckNeed;
	logic beatTake;
	logic beatPush;
	logic [2:0] beatOfs;
	logic [9:0] beatCol;
	logic [15:0] pinAddr;
	logic [2:0] pinBank;
	logic chopNow;

	always_comb
	begin
		pinAddr = r_q.sync3[ddwb_pkg::PIN_ADDR_HI:ddwb_pkg::PIN_ADDR_LO];
		pinBank = r_q.sync3[ddwb_pkg::PIN_BA_HI:ddwb_pkg::PIN_BA_LO];
		// Edges count once the second and third stages agree
		ckRise = (r_q.sync2[ddwb_pkg::PIN_CK] == r_q.sync3[ddwb_pkg::PIN_CK])
			&& r_q.sync3[ddwb_pkg::PIN_CK] && !r_q.ckLvl;
		dqsEdge = (r_q.sync2[ddwb_pkg::PIN_DQS] == r_q.sync3[ddwb_pkg::PIN_DQS])
			&& (r_q.sync3[ddwb_pkg::PIN_DQS] != r_q.dqsLvl);
		cmdValid = ckRise && !r_q.sync3[ddwb_pkg::PIN_CS_N];
		isWrite = cmdValid && r_q.sync3[ddwb_pkg::PIN_RAS_N]
			&& !r_q.sync3[ddwb_pkg::PIN_CAS_N] && !r_q.sync3[ddwb_pkg::PIN_WE_N];
		isPrecharge = cmdValid && !r_q.sync3[ddwb_pkg::PIN_RAS_N]
			&& r_q.sync3[ddwb_pkg::PIN_CAS_N] && !r_q.sync3[ddwb_pkg::PIN_WE_N];
		isActivate = cmdValid && !r_q.sync3[ddwb_pkg::PIN_RAS_N]
			&& r_q.sync3[ddwb_pkg::PIN_CAS_N] && r_q.sync3[ddwb_pkg::PIN_WE_N];
		// Burst length per mode field and A12
		case (burstMode)
			ddwb_pkg::BURST_FIXED8: chopNow = 1'b0;
			ddwb_pkg::BURST_OTF: chopNow = !pinAddr[ddwb_pkg::ADDR_CHOP];
			ddwb_pkg::BURST_FIXED4: chopNow = 1'b1;
			default: chopNow = 1'b0;
		endcase
		beatsNeed = r_q.chop ? ddwb_pkg::BEATS_CHOP : ddwb_pkg::BEATS_FULL;
		ckNeed = r_q.chop ? ddwb_pkg::CK_CHOP : ddwb_pkg::CK_FULL;
		// Only edges inside an open burst are taken
		beatTake = (r_q.state == ddwb_pkg::ST_BURST) && r_q.preSeen && dqsEdge;
		// Mask is consulted only inside a write burst, never for reads
		beatPush = beatTake && !r_q.sync3[ddwb_pkg::PIN_DM];
		// Wrap order inside the burst block
		beatOfs = r_q.col[2:0] + r_q.beat[2:0];
		if (r_q.chop)
		begin
			beatCol = {r_q.col[9:2], beatOfs[1:0]};
		end
		else
		begin
			beatCol = {r_q.col[9:3], beatOfs};
		end
	end

	always_comb
	begin
		r_d = r_q;
		r_d.sync1 = {ddrClk, csN, rasN, casN, weN, bankAddr, addr, dqs, dq, dm};
		r_d.sync2 = r_q.sync1;
		r_d.sync3 = r_q.sync2;
		if (r_q.sync2[ddwb_pkg::PIN_CK] == r_q.sync3[ddwb_pkg::PIN_CK])
		begin
			r_d.ckLvl = r_q.sync3[ddwb_pkg::PIN_CK];
		end
		if (r_q.sync2[ddwb_pkg::PIN_DQS] == r_q.sync3[ddwb_pkg::PIN_DQS])
		begin
			r_d.dqsLvl = r_q.sync3[ddwb_pkg::PIN_DQS];
		end

		// Two-entry buffer: pop first, then push
		if (r_q.headVal && storeReady)
		begin
			r_d.head = r_q.tail;
			r_d.headVal = r_q.tailVal;
			r_d.tailVal = 1'b0;
		end
		if (beatPush)
		begin
			if (!r_d.headVal)
			begin
				r_d.head = {r_q.bank, beatCol, r_q.sync3[ddwb_pkg::PIN_DQ_HI:ddwb_pkg::PIN_DQ_LO]};
				r_d.headVal = 1'b1;
			end
			else if (!r_d.tailVal)
			begin
				r_d.tail = {r_q.bank, beatCol, r_q.sync3[ddwb_pkg::PIN_DQ_HI:ddwb_pkg::PIN_DQ_LO]};
				r_d.tailVal = 1'b1;
			end
			else
			begin
				r_d.overrun = 1'b1;
			end
		end

		case (r_q.state)
			ddwb_pkg::ST_IDLE:
			begin
				if (isWrite)
				begin
					r_d.state = ddwb_pkg::ST_BURST;
					r_d.ckCnt = 6'h00;
					r_d.wlat = {2'h0, addLat} + {2'h0, casWriteLat};
					r_d.chop = chopNow;
					r_d.bank = pinBank;
					r_d.col = pinAddr[9:0];
					r_d.beat = 4'h0;
					r_d.preSeen = 1'b0;
					r_d.overrun = 1'b0;
					r_d.abort = 1'b0;
				end
			end
			ddwb_pkg::ST_BURST:
			begin
				if (ckRise)
				begin
					r_d.ckCnt = r_q.ckCnt + 6'h01;
				end
				// Preamble: strobe low from one clock before latency
				if (!r_q.preSeen && (r_q.ckCnt + 6'h01 >= r_q.wlat) && !r_q.dqsLvl)
				begin
					r_d.preSeen = 1'b1;
				end
				if (beatTake)
				begin
					r_d.beat = r_q.beat + 4'h1;
					if (r_q.beat + 4'h1 == beatsNeed)
					begin
						r_d.state = ddwb_pkg::ST_IDLE;
					end
				end
				else if (r_q.ckCnt > r_q.wlat + ckNeed + ddwb_pkg::CK_SLACK)
				begin
					// Missing strobe edges end the burst, never a hang
					r_d.state = ddwb_pkg::ST_IDLE;
					r_d.abort = 1'b1;
				end
			end
			default: r_d.state = ddwb_pkg::ST_IDLE;
		endcase
		// Busy kept in its own flop so the output leaves a register
		r_d.busy = (r_d.state == ddwb_pkg::ST_BURST);

		if (isActivate)
		begin
			r_d.bankOpen[pinBank] = 1'b1;
		end
		if (isPrecharge)
		begin
			if (pinAddr[ddwb_pkg::ADDR_ALLBANK])
			begin
				r_d.bankOpen = 8'h00;
			end
			else
			begin
				r_d.bankOpen[pinBank] = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			r_q <= '0;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	assign storeValid = r_q.headVal;
	assign storeBank = r_q.head[ddwb_pkg::BEAT_W-1 -: 3];
	assign storeCol = r_q.head[ddwb_pkg::DATA_W +: ddwb_pkg::COL_W];
	assign storeData = r_q.head[ddwb_pkg::DATA_W-1:0];
	assign bankOpen = r_q.bankOpen;
	assign burstBusy = r_q.busy;
	assign overrun = r_q.overrun;
	assign burstAbort = r_q.abort;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence writeInIdle;
		isWrite && (r_q.state == ddwb_pkg::ST_IDLE);
	endsequence

	sequence burstOpened;
		##1 (r_q.state == ddwb_pkg::ST_BURST) && (r_q.beat == 4'h0);
	endsequence

	a_write_opens_burst: assert property (writeInIdle |-> burstOpened)
		else $error("Write command did not open a burst");
	a_latency_sum: assert property (
		writeInIdle |=> r_q.wlat == $past({2'h0, addLat}) + $past({2'h0, casWriteLat}))
		else $error("Write latency is not AL plus CWL");
	a_chop_select: assert property (
		writeInIdle and (burstMode == ddwb_pkg::BURST_OTF)
		|=> r_q.chop == !$past(pinAddr[ddwb_pkg::ADDR_CHOP]))
		else $error("A12 did not select burst length");
	a_fixed_modes: assert property (
		writeInIdle and (burstMode == ddwb_pkg::BURST_FIXED4) |=> r_q.chop)
		else $error("Fixed chop mode gave a full burst");
	a_fixed_eight: assert property (
		writeInIdle and (burstMode == ddwb_pkg::BURST_FIXED8) |=> !r_q.chop)
		else $error("Fixed eight mode gave a chopped burst");
	a_col_no_a12: assert property (writeInIdle |=> r_q.col == $past(pinAddr[9:0]))
		else $error("Column address taken wrongly");
	a_beats_bounded: assert property (
		r_q.state == ddwb_pkg::ST_BURST |-> r_q.beat < beatsNeed)
		else $error("Burst ran past its length");
	a_idle_no_store: assert property (
		r_q.state == ddwb_pkg::ST_IDLE |=> !$rose(r_q.headVal) && !$rose(r_q.tailVal))
		else $error("Data stored outside a burst");
	a_mask_blocks: assert property (
		beatTake && r_q.sync3[ddwb_pkg::PIN_DM] && !(r_q.headVal && storeReady)
		|=> r_q.headVal == $past(r_q.headVal) && r_q.tailVal == $past(r_q.tailVal))
		else $error("Masked byte was stored");
	a_no_hang: assert property (
		r_q.state == ddwb_pkg::ST_BURST
		|-> r_q.ckCnt <= r_q.wlat + ckNeed + ddwb_pkg::CK_SLACK + 6'h01)
		else $error("Burst outlived its window");
	a_precharge_all: assert property (
		isPrecharge && pinAddr[ddwb_pkg::ADDR_ALLBANK] |=> r_q.bankOpen == 8'h00)
		else $error("All-bank precharge left a bank open");
	a_precharge_one: assert property (
		isPrecharge && !pinAddr[ddwb_pkg::ADDR_ALLBANK]
		|=> !r_q.bankOpen[$past(pinBank)] && ((r_q.bankOpen | (8'h01 << $past(pinBank)))
		== ($past(r_q.bankOpen) | (8'h01 << $past(pinBank)))))
		else $error("Single-bank precharge touched the wrong bank");

endmodule : ddwb_core

// ==== verification/ddwb_ctrl_model.sv ====
// Controller model: link clock, command pins, write strobe and data.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module ddwb_ctrl_model
#(
	parameter int WR_CK = 8
)
(
	output logic ddrClk,
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic [2:0] bankAddr,
	output logic [15:0] addr,
	output logic dqs,
	output logic [7:0] dq,
	output logic dm
);
	initial
	begin
		{ddrClk, csN, rasN, casN, weN, dqs, dm, dq, bankAddr, addr} = '1;
		forever #100 ddrClk = ~ddrClk;
	end
	// Pins held a whole link cycle around one rising edge
	task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
		@(negedge ddrClk);
		{csN, rasN, casN, weN} = {1'b0, c};
		bankAddr = b;
		addr = a;
		@(negedge ddrClk);
		csN = 1'b1;
		bankAddr = ~b;
		addr = ~a;
	endtask : cmd
	task automatic precharge(input logic [2:0] b, input logic [15:0] a);
		repeat (WR_CK) @(posedge ddrClk);
		cmd(3'b010, b, a);
	endtask : precharge
	// Beats centred on strobe edges; extra edges carry junk
	task automatic burst(input logic [2:0] b, input logic [15:0] a, input int wl, input int n,
		input int extra, input logic [63:0] d, input logic [7:0] m);
		cmd(3'b100, b, a);
		repeat (wl - 1) @(posedge ddrClk);
		dqs = 1'b0;
		#150;
		for (int k = 0; k < n + extra; k++)
		begin
			dq = (k < n) ? d[8*(k%8) +: 8] : ~dq;
			dm = m[k%8];
			#50 dqs = ~dqs;
			#50;
		end
		dqs = 1'b1;
		dq = ~dq;
	endtask : burst
endmodule : ddwb_ctrl_model

// ==== verification/test_ddr3_write_burst_and_precharge.sv ====
// Bench for the write burst block: drives modes, drains the store buffer, checks beats.
// Assumes the controller model drives every link pin.
`timescale 1ns/1ps
module test_ddr3_write_burst_and_precharge;
	logic mclk = 0, sys_rst = 1, storeReady = 0;
	logic [1:0] burstMode = 0;
	logic [3:0] addLat = 0, casWriteLat = 5;
	logic ddrClk, csN, rasN, casN, weN, dqs, dm, storeValid, burstBusy, overrun, burstAbort;
	logic [2:0] bankAddr, storeBank;
	logic [15:0] addr;
	logic [7:0] dq, storeData, bankOpen;
	logic [9:0] storeCol;
	logic [20:0] expQ[$];
	logic [31:0] lfsr = 32'h9dee;
	int fails = 0, checksDone = 0;
	ddwb_core DUT (.mclk, .sys_rst, .ddrClk, .csN, .rasN, .casN, .weN, .bankAddr, .addr, .dqs,
		.dq, .dm, .burstMode, .addLat, .casWriteLat, .storeReady, .storeValid, .storeBank,
		.storeCol, .storeData, .bankOpen, .burstBusy, .overrun, .burstAbort);
	ddwb_ctrl_model u_ctrl (.ddrClk, .csN, .rasN, .casN, .weN, .bankAddr, .addr, .dqs, .dq, .dm);
	initial
	begin
		forever #12.5 mclk = ~mclk;
	end
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand
	task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
		checksDone++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d errors %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	// Drain side stalls about a quarter of the cycles
	always @(posedge mclk)
	begin
		lfsr <= nextRand(lfsr);
		storeReady <= #1 (lfsr[1:0] != 2'h0);
		if (storeValid === 1'b1 && storeReady === 1'b1)
			check("beat", expQ.size() ? expQ.pop_front() : 'x, {storeBank, storeCol, storeData});
	end
	task automatic doWrite(input logic [1:0] mode, input logic chop, input int n, input int extra);
		logic [63:0] d;
		logic [7:0] m;
		logic [15:0] a;
		int beats;
		int i;
		int len;
		@(posedge mclk);
		#1;
		burstMode = mode;
		d = {lfsr, nextRand(lfsr)};
		m = lfsr[15:8] & lfsr[23:16];
		a = lfsr[31:16];
		a[12] = chop;
		beats = (mode == 2'h2 || (mode == 2'h1 && !chop)) ? 4 : 8;
		len = n ? n : beats;
		for (int k = 0; k < len; k++)
			if (!m[k])
				expQ.push_back({lfsr[2:0], beats == 8 ? {a[9:3], a[2:0] + k[2:0]} :
					{a[9:2], a[1:0] + k[1:0]}, d[8*k +: 8]});
		u_ctrl.burst(lfsr[2:0], a, addLat + casWriteLat, len, extra, d, m);
		for (i = 0; i < 800 && (burstBusy !== 1'b0 || expQ.size() != 0); i++)
			@(posedge mclk);
		if (i == 800)
		begin
			fails++;
			$display("[ERR] burst end expected 0 seen %0d", expQ.size());
			print_verdict();
		end
		check("abort", n != 0, burstAbort);
		check("overrun", 0, overrun);
	endtask : doWrite
	initial
	begin
		repeat (10) @(posedge mclk);
		#1 sys_rst = 0;
		repeat (4) @(posedge mclk);
		check("open", 0, bankOpen);
		for (int i = 0; i < 8; i++)
			u_ctrl.cmd(3'b011, i[2:0], 16'h0);
		repeat (8) @(posedge mclk);
		check("open", 8'hff, bankOpen);
		for (int i = 0; i < 8; i++)
		begin
			u_ctrl.precharge(i[2:0], lfsr[15:0] & 16'hfbff);
			repeat (8) @(posedge mclk);
			check("open", 8'(8'hff << (i + 1)), bankOpen);
		end
		u_ctrl.cmd(3'b011, 3'h6, 16'h0);
		u_ctrl.cmd(3'b011, 3'h1, 16'h0);
		u_ctrl.precharge(3'h3, 16'h0400);
		repeat (8) @(posedge mclk);
		check("open", 0, bankOpen);
		u_ctrl.cmd(3'b101, 3'h2, 16'h0);
		repeat (8) @(posedge mclk);
		check("read busy", 0, burstBusy);
		for (int k = 0; k < 8; k++)
		begin
			addLat = k[1:0];
			casWriteLat = 4'h5 + k[2:1];
			doWrite(k[2:1], k[0], 0, 2);
		end
		doWrite(2'h0, 1'b1, 3, 0);
		// Write burst block is reset through sys_rst after the violated burst
		#1 sys_rst = 1;
		repeat (10) @(posedge mclk);
		#1 sys_rst = 0;
		repeat (4) @(posedge mclk);
		check("abort", 0, burstAbort);
		doWrite(2'h1, 1'b0, 0, 2);
		print_verdict();
	end
endmodule : test_ddr3_write_burst_and_precharge
